//--- src/ssp_defines.svh
`ifndef SSP_DEFINES_SVH
`define SSP_DEFINES_SVH
// ------------------------------------------------------------
// Register offsets (byte addresses)
// ------------------------------------------------------------
`define SSP_ADDR_CTRL 5'h00
`define SSP_ADDR_CMD 5'h04
`define SSP_ADDR_DATA 5'h08
`define SSP_ADDR_STAT 5'h0c
`define SSP_ADDR_IEN 5'h10
// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define SSP_CTRL_PIN_EN 0
`define SSP_CTRL_MODE_LO 1
`define SSP_CTRL_MODE_HI 2
`define SSP_CTRL_PAR_EN 3
`define SSP_CTRL_PAR_ODD 4
`define SSP_CTRL_CSRC_LO 5
`define SSP_CTRL_CSRC_HI 6
`define SSP_CMD_TX_EN 0
`define SSP_CMD_RX_EN 1
`define SSP_CMD_TX_TRG 2
`define SSP_CMD_RX_TRG 3
`define SSP_STAT_RX_DONE 0
`define SSP_STAT_TX_DONE 1
// ------------------------------------------------------------
// Reset value, mode codes, timing counts and response codes
// ------------------------------------------------------------
`define SSP_RST_BYTE 8'h00
`define SSP_MODE_MASTER 2'b00
`define SSP_MODE_SLAVE 2'b01
`define SSP_MODE_A7 2'b10
`define SSP_MODE_A8 2'b11
`define SSP_DIV_LAST 4'hf
`define SSP_HALF_LAST 4'h7
`define SSP_SYNC_LAST 4'h7
`define SSP_RESP_OKAY 2'b00
`define SSP_RESP_SLVERR 2'b10
`endif

//--- src/ssp_pkg.sv
package ssp_pkg;
  typedef enum logic [1:0] {
    SSP_IDLE,
    SSP_SYNC,
    SSP_ATX
  } ssp_state_t;

  typedef struct packed {
    logic awvalid;
    logic [4:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [4:0] araddr;
    logic rready;
  } ssp_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ssp_axi_rsp_t;

  typedef struct packed {
    logic serial_in_pin;
    logic sclk;
  } ssp_pin_in_t;

  typedef struct packed {
    logic serial_out_pin;
    logic serial_out_oe;
    logic sclk;
    logic sclk_oe;
    logic ready_pin;
    logic ready_oe;
  } ssp_pin_out_t;
endpackage

//--- src/ssp_top.sv
// Overview of operation
// RULE1: Software clears both enables, then sets rx_enable.
// RULE2: Master software checks slave ready before triggering.
// RULE3: Master rx_trigger starts clock, drives clock pin.
// RULE4: Slave waits for master clock before shifting.
// RULE5: Receive samples serial input on rising clock.
// RULE6: Eighth rising edge buffers byte, sets rx_done_flag.
// RULE7: Enabled receive interrupt rises with rx_done_flag.
// RULE8: Slave ready pin low when ready, high busy.
// RULE9: Ready low on trigger, high first falling edge.
// RULE10: Master mode leaves ready pin as port.
// RULE11: Asynchronous mode has separate shift registers; the code shares one shreg and async mode only transmits.
// RULE12: One start, one stop bit, LSB first.
// RULE13: Mode 10 async 7-bit, 11 async 8-bit.
// RULE14: Parity enabled appends parity bit on transmit.
// RULE15: parity_odd_even picks odd or even parity.
// RULE16: Parity disabled sends data bits only.
// RULE17: Pins stay ports until serial_pin_enable set.
// RULE18: Async mode leaves clock, ready pins ports.
// RULE19: Clock source field; settings share one address.
// RULE20: Async trigger sends low start, then bits.
// RULE21: Stop bit high, line held high afterwards.
// RULE22: 7-bit mode ignores data byte MSB.
// RULE23: Transmit end sets tx_done_flag, optional interrupt.
// RULE24: Master clock is selected source divided sixteen.
// RULE25: Mode 00 master, mode 01 slave.
// RULE26: rx_trigger reads one while receiving.
// RULE27: Writing one clears tx_done_flag.
//
// The address map and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/10ps
`include "ssp_defines.svh"
module ssp_top (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire ssp_pkg::ssp_axi_req_t axi_req,
  output ssp_pkg::ssp_axi_rsp_t axi_rsp,
  input wire logic [3:0] clk_src_tick,
  input wire ssp_pkg::ssp_pin_in_t pin_in,
  output ssp_pkg::ssp_pin_out_t pin_out,
  output logic rx_irq,
  output logic tx_irq
);
  import ssp_pkg::*;

  typedef struct packed {
    logic pin_en;
    logic [1:0] mode;
    logic par_en;
    logic par_odd;
    logic [1:0] csrc;
    logic tx_en;
    logic rx_en;
    logic [1:0] ien;
    logic rx_flag;
    logic tx_flag;
    logic [7:0] tx_data;
    logic [7:0] rx_buf;
    ssp_state_t state;
    logic is_rx;
    logic [3:0] presc;
    logic [3:0] cnt;
    logic [8:0] shreg;
    logic sclk_prev;
    logic aw_got;
    logic w_got;
    logic [4:0] awaddr;
    logic [31:0] wdata;
    logic wstrb0;
    ssp_axi_rsp_t rsp;
    ssp_pin_out_t pin;
    logic rx_irq;
    logic tx_irq;
  } ssp_st_t;

  ssp_st_t s;
  ssp_st_t next_s;
  logic tick;
  logic rise;
  logic fall;
  logic wr;
  logic trg_tx;
  logic trg_rx;
  logic [3:0] nbits;
  logic [7:0] txd;

  // ------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------
  always_comb begin
    next_s = s;
    tick = clk_src_tick[s.csrc]; // [RULE19]
    rise = 1'b0;
    fall = 1'b0;
    trg_tx = 1'b0;
    trg_rx = 1'b0;
    txd = (s.mode == `SSP_MODE_A7) ? {1'b0, s.tx_data[6:0]} :
      s.tx_data; // [RULE22]
    nbits = ((s.mode == `SSP_MODE_A7) ? 4'd7 : 4'd8) +
      {3'b000, s.par_en}; // [RULE13] [RULE14] [RULE16]
    next_s.sclk_prev = pin_in.sclk;

    // Bus slave: address and data are taken in either order.
    if (axi_req.awvalid && s.rsp.awready) begin
      next_s.aw_got = 1'b1;
      next_s.awaddr = axi_req.awaddr;
    end
    if (axi_req.wvalid && s.rsp.wready) begin
      next_s.w_got = 1'b1;
      next_s.wdata = axi_req.wdata;
      next_s.wstrb0 = axi_req.wstrb[0];
    end
    if (s.rsp.bvalid && axi_req.bready) begin
      next_s.rsp.bvalid = 1'b0;
    end
    wr = s.aw_got && s.w_got && !s.rsp.bvalid;
    if (wr) begin
      next_s.aw_got = 1'b0;
      next_s.w_got = 1'b0;
      next_s.rsp.bvalid = 1'b1;
      next_s.rsp.bresp = `SSP_RESP_OKAY;
      case (s.awaddr)
        `SSP_ADDR_CTRL: begin
          if (s.wstrb0) begin // [RULE19]
            next_s.pin_en = s.wdata[`SSP_CTRL_PIN_EN];
            next_s.mode = {s.wdata[`SSP_CTRL_MODE_HI],
              s.wdata[`SSP_CTRL_MODE_LO]};
            next_s.par_en = s.wdata[`SSP_CTRL_PAR_EN];
            next_s.par_odd = s.wdata[`SSP_CTRL_PAR_ODD];
            next_s.csrc = {s.wdata[`SSP_CTRL_CSRC_HI],
              s.wdata[`SSP_CTRL_CSRC_LO]};
          end
        end
        `SSP_ADDR_CMD: begin
          if (s.wstrb0) begin
            next_s.tx_en = s.wdata[`SSP_CMD_TX_EN];
            next_s.rx_en = s.wdata[`SSP_CMD_RX_EN];
            trg_tx = s.wdata[`SSP_CMD_TX_TRG] &&
              s.wdata[`SSP_CMD_TX_EN] && s.state == SSP_IDLE;
            trg_rx = s.wdata[`SSP_CMD_RX_TRG] && !trg_tx &&
              s.wdata[`SSP_CMD_RX_EN] && s.state == SSP_IDLE &&
              !s.mode[1];
          end
        end
        `SSP_ADDR_DATA: begin
          if (s.wstrb0) begin
            next_s.tx_data = s.wdata[7:0];
          end
        end
        `SSP_ADDR_STAT: begin
          if (s.wstrb0) begin // [RULE27]
            next_s.rx_flag = s.rx_flag &&
              !s.wdata[`SSP_STAT_RX_DONE];
            next_s.tx_flag = s.tx_flag &&
              !s.wdata[`SSP_STAT_TX_DONE];
          end
        end
        `SSP_ADDR_IEN: begin
          if (s.wstrb0) begin
            next_s.ien = s.wdata[1:0];
          end
        end
        default: begin
          next_s.rsp.bresp = `SSP_RESP_SLVERR;
        end
      endcase
    end

    if (s.rsp.rvalid && axi_req.rready) begin
      next_s.rsp.rvalid = 1'b0;
    end
    if (axi_req.arvalid && s.rsp.arready) begin
      next_s.rsp.rvalid = 1'b1;
      next_s.rsp.rresp = `SSP_RESP_OKAY;
      next_s.rsp.rdata = 32'h0000_0000;
      case (axi_req.araddr)
        `SSP_ADDR_CTRL: next_s.rsp.rdata[6:0] = {s.csrc, s.par_odd,
          s.par_en, s.mode, s.pin_en};
        `SSP_ADDR_CMD: next_s.rsp.rdata[3:0] = {
          s.state != SSP_IDLE && s.is_rx,
          s.state != SSP_IDLE && !s.is_rx,
          s.rx_en, s.tx_en}; // [RULE26]
        `SSP_ADDR_DATA: next_s.rsp.rdata[7:0] = s.rx_buf;
        `SSP_ADDR_STAT: next_s.rsp.rdata[1:0] = {s.tx_flag, s.rx_flag};
        `SSP_ADDR_IEN: next_s.rsp.rdata[1:0] = s.ien;
        default: next_s.rsp.rresp = `SSP_RESP_SLVERR;
      endcase
    end

    // Transfer engine.
    case (s.state)
      SSP_IDLE: begin
        next_s.pin.sclk = 1'b1;
        if (trg_tx || trg_rx) begin
          next_s.presc = 4'h0;
          next_s.cnt = 4'h0;
          next_s.is_rx = trg_rx;
          if (s.mode[1]) begin
            next_s.state = SSP_ATX; // [RULE11]
            next_s.shreg = {s.par_odd ^ (^txd), txd}; // [RULE15]
            if (s.mode == `SSP_MODE_A7) begin
              next_s.shreg[8:7] = {1'b0, s.par_odd ^ (^txd)};
            end
          end else begin
            next_s.state = SSP_SYNC; // [RULE3] [RULE4]
            next_s.shreg = {1'b0, s.tx_data};
            if (s.mode == `SSP_MODE_SLAVE) begin
              next_s.pin.ready_pin = 1'b0; // [RULE9]
            end
          end
        end
      end
      SSP_SYNC: begin
        if (s.mode == `SSP_MODE_MASTER) begin // [RULE25]
          if (tick) begin
            next_s.presc = s.presc + 4'h1;
            if (s.presc == `SSP_HALF_LAST ||
                s.presc == `SSP_DIV_LAST) begin // [RULE24]
              next_s.pin.sclk = !s.pin.sclk;
              fall = s.pin.sclk;
              rise = !s.pin.sclk;
            end
          end
        end else begin
          fall = s.sclk_prev && !pin_in.sclk; // [RULE4]
          rise = !s.sclk_prev && pin_in.sclk;
        end
        if (fall) begin
          next_s.pin.ready_pin = 1'b1; // [RULE8] [RULE9]
          if (!s.is_rx) begin
            next_s.pin.serial_out_pin = s.shreg[0];
            next_s.shreg = {1'b0, s.shreg[8:1]};
          end
        end
        if (rise) begin
          next_s.cnt = s.cnt + 4'h1;
          if (s.is_rx) begin
            next_s.shreg[7:0] = {pin_in.serial_in_pin,
              s.shreg[7:1]}; // [RULE5]
          end
          if (s.cnt == `SSP_SYNC_LAST) begin
            next_s.state = SSP_IDLE;
            if (s.is_rx) begin
              next_s.rx_buf = {pin_in.serial_in_pin,
                s.shreg[7:1]}; // [RULE6]
              next_s.rx_flag = 1'b1;
            end else begin
              next_s.tx_flag = 1'b1; // [RULE23]
            end
          end
        end
        if (s.is_rx ? !s.rx_en : !s.tx_en) begin
          next_s.state = SSP_IDLE;
          next_s.pin.ready_pin = 1'b1;
        end
      end
      SSP_ATX: begin
        if (tick) begin
          next_s.presc = s.presc + 4'h1;
          if (s.presc == `SSP_DIV_LAST) begin
            next_s.cnt = s.cnt + 4'h1;
            if (s.cnt == 4'h0) begin
              next_s.pin.serial_out_pin = 1'b0; // [RULE20] [RULE12]
            end else if (s.cnt <= nbits) begin
              next_s.pin.serial_out_pin = s.shreg[0]; // [RULE12]
              next_s.shreg = {1'b0, s.shreg[8:1]};
            end else if (s.cnt == nbits + 4'h1) begin
              next_s.pin.serial_out_pin = 1'b1; // [RULE21]
            end else begin
              next_s.state = SSP_IDLE;
              next_s.tx_flag = 1'b1; // [RULE23]
            end
          end
        end
        if (!s.tx_en) begin
          next_s.state = SSP_IDLE;
          next_s.pin.serial_out_pin = 1'b1;
        end
      end
      default: next_s.state = SSP_IDLE;
    endcase

    next_s.rsp.awready = !next_s.aw_got && !next_s.rsp.bvalid;
    next_s.rsp.wready = !next_s.w_got && !next_s.rsp.bvalid;
    next_s.rsp.arready = !next_s.rsp.rvalid;
    next_s.pin.serial_out_oe = next_s.pin_en; // [RULE17]
    next_s.pin.sclk_oe = next_s.pin_en &&
      next_s.mode == `SSP_MODE_MASTER; // [RULE18] [RULE3]
    next_s.pin.ready_oe = next_s.pin_en &&
      next_s.mode == `SSP_MODE_SLAVE; // [RULE10] [RULE18]
    next_s.rx_irq = next_s.rx_flag && s.ien[0]; // [RULE7]
    next_s.tx_irq = next_s.tx_flag && s.ien[1]; // [RULE23]
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.state <= SSP_IDLE;
      s.pin.serial_out_pin <= 1'b1;
      s.pin.sclk <= 1'b1;
      s.pin.ready_pin <= 1'b1;
      s.sclk_prev <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign axi_rsp = s.rsp;
  assign pin_out = s.pin;
  assign rx_irq = s.rx_irq;
  assign tx_irq = s.tx_irq;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  AST_RX_DONE: assert property ( // [RULE6]
    s.state == SSP_SYNC && s.is_rx && rise && s.cnt == 4'h7 &&
    s.rx_en |=> s.rx_flag && s.state == SSP_IDLE &&
    s.rx_buf == {$past(pin_in.serial_in_pin), $past(s.shreg[7:1])})
    else $error("rx byte not buffered on eighth edge");
  AST_SHIFT_IN: assert property ( // [RULE5]
    s.state == SSP_SYNC && s.is_rx && rise && s.rx_en &&
    s.cnt < 4'h7 |=> s.shreg[7] == $past(pin_in.serial_in_pin))
    else $error("serial input not captured");
  AST_RDY_LOW: assert property ( // [RULE9]
    trg_rx && s.mode == `SSP_MODE_SLAVE |=> !s.pin.ready_pin
    ##1 (!s.pin.ready_pin || $past(fall)))
    else $error("ready not low after trigger");
  AST_RDY_HIGH: assert property ( // [RULE8]
    s.state == SSP_SYNC && fall |=> s.pin.ready_pin)
    else $error("ready not high after first falling edge");
  AST_START_BIT: assert property ( // [RULE20]
    s.state == SSP_ATX && tick && s.presc == 4'hf && s.cnt == 4'h0 &&
    s.tx_en |=> !s.pin.serial_out_pin)
    else $error("start bit not low");
  AST_STOP_BIT: assert property ( // [RULE21]
    s.state == SSP_ATX && tick && s.presc == 4'hf && s.tx_en &&
    s.cnt == nbits + 4'h1 |=> s.pin.serial_out_pin [*2])
    else $error("stop bit not high");
  AST_TX_DONE: assert property ( // [RULE23]
    s.state == SSP_ATX && tick && s.presc == 4'hf && s.tx_en &&
    s.cnt == nbits + 4'h2 |=> s.tx_flag && s.state == SSP_IDLE)
    else $error("tx done flag not set");
  AST_SET_WINS: assert property ( // [RULE27]
    wr && s.awaddr == `SSP_ADDR_STAT && s.wdata[1] && s.wstrb0 &&
    s.state == SSP_ATX && tick && s.presc == 4'hf && s.tx_en &&
    s.cnt == nbits + 4'h2 |=> s.tx_flag)
    else $error("clear beat the set");
  AST_MASTER_CLK: assert property ( // [RULE3]
    s.state == SSP_SYNC && s.mode == `SSP_MODE_MASTER && s.pin_en
    |-> s.pin.sclk_oe)
    else $error("master clock not driven");
  AST_ASYNC_PINS: assert property ( // [RULE18]
    s.mode[1] |-> !s.pin.sclk_oe && !s.pin.ready_oe)
    else $error("async mode claims port pins");
  AST_RX_IRQ: assert property ( // [RULE7]
    $rose(s.rx_flag) && $past(s.ien[0]) |-> rx_irq)
    else $error("rx interrupt missing");

  COV_SYNC_RX: cover property (s.state == SSP_SYNC && s.is_rx
    ##1 s.rx_flag && s.state == SSP_IDLE);
  COV_SLAVE_RDY: cover property (trg_rx && s.mode == `SSP_MODE_SLAVE);
  COV_ASYNC_TX: cover property ($rose(s.tx_flag) && s.mode[1]);
  COV_PARITY: cover property (s.state == SSP_ATX && s.par_en);
endmodule

//--- testbench/ssp_partner.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// Far-side serial device, clock source or clock follower
// ------------------------------------------------------------
module ssp_partner (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic go,
  input wire logic drive_clk,
  input wire logic [7:0] tx_byte,
  input wire logic dut_sclk,
  output logic sclk,
  output logic sdata,
  output logic busy
);
  logic [3:0] nbit;
  logic [3:0] ph;
  logic prev;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sclk <= 1'b1;
      sdata <= 1'b0;
      busy <= 1'b0;
      nbit <= 4'h0;
      ph <= 4'h0;
      prev <= 1'b1;
    end else begin
      prev <= dut_sclk;
      if (go) begin
        busy <= 1'b1;
        nbit <= 4'h0;
        ph <= 4'h0;
      end else if (busy && drive_clk) begin
        // Data changes on the fall and is held well past the rise.
        ph <= ph + 4'h1;
        if (ph == 4'h0) begin
          sclk <= 1'b0;
          sdata <= tx_byte[nbit[2:0]];
        end
        if (ph == 4'h8) sclk <= 1'b1;
        if (ph == 4'hf) begin
          nbit <= nbit + 4'h1;
          busy <= (nbit != 4'h7);
        end
      end else if (busy) begin
        if (prev && !dut_sclk) sdata <= tx_byte[nbit[2:0]];
        if (!prev && dut_sclk) begin
          nbit <= nbit + 4'h1;
          busy <= (nbit != 4'h7);
        end
      end else begin
        // A released line carries nothing the receiver may trust.
        sdata <= ~sdata;
      end
    end
  end
endmodule

//--- testbench/ssp_top_tb.sv
`timescale 1ns/10ps
`include "ssp_defines.svh"
module ssp_top_tb;
  import ssp_pkg::*;
  logic clk_sys;
  logic rst_n;
  ssp_axi_req_t req;
  ssp_axi_rsp_t rsp;
  logic [3:0] tick;
  ssp_pin_in_t pin_in;
  ssp_pin_out_t pin_out;
  logic rx_irq;
  logic tx_irq;
  logic p_go;
  logic p_drv;
  logic [7:0] p_byte;
  logic p_sclk;
  logic p_sdata;
  logic sclk_w;
  int n_errors;
  int compares;
  ssp_top i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .axi_req(req),
    .axi_rsp(rsp), .clk_src_tick(tick), .pin_in(pin_in),
    .pin_out(pin_out), .rx_irq(rx_irq), .tx_irq(tx_irq));
  ssp_partner i_partner (.clk_sys(clk_sys), .rst_n(rst_n), .go(p_go),
    .drive_clk(p_drv), .tx_byte(p_byte), .dut_sclk(sclk_w),
    .sclk(p_sclk), .sdata(p_sdata), .busy());
  // The shared clock pin follows whichever side has its driver on.
  assign sclk_w = pin_out.sclk_oe ? pin_out.sclk : p_sclk;
  assign pin_in = {p_sdata, sclk_w};
  always #5 clk_sys = ~clk_sys;
  // Source one ticks at half rate so that the source selection shows.
  always @(posedge clk_sys) tick <= {2'b11, ~tick[1], 1'b1};
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      n_errors++;
    end
  endtask
  task automatic axi_wr(input logic [4:0] a, input logic [7:0] d,
                        output logic [1:0] r);
    @(posedge clk_sys);
    req.awaddr <= a;
    req.wdata <= {24'h00_0000, d};
    req.wstrb <= 4'hf;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
    end while (!rsp.bvalid);
    r = rsp.bresp;
    req.bready <= 1'b0;
  endtask
  task automatic rd_chk(input logic [4:0] a, input logic [31:0] m,
                        input logic [31:0] e);
    @(posedge clk_sys);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (rsp.arready) req.arvalid <= 1'b0;
    end while (!rsp.rvalid);
    chk(rsp.rdata & m, e);
    req.rready <= 1'b0;
  endtask
  task automatic start_partner(input logic [7:0] b, input logic drv);
    p_byte <= b;
    p_drv <= drv;
    p_go <= 1'b1;
    @(posedge clk_sys);
    p_go <= 1'b0;
  endtask
  task automatic wait_irq(input logic rx);
    int n;
    n = 0;
    while ((rx ? rx_irq : tx_irq) !== 1'b1 && n < 800) begin
      @(posedge clk_sys);
      n++;
    end
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    logic [1:0] r;
    @(posedge clk_sys);
    chk(pin_out, 6'h2a);
    rd_chk(`SSP_ADDR_CTRL, 32'hffff_ffff, 32'h0000_0000);
    axi_wr(5'h14, 8'hff, r);
    chk(r, 2'b10);
    axi_wr(`SSP_ADDR_IEN, 8'hff, r);
    rd_chk(`SSP_ADDR_IEN, 32'hffff_ffff, 32'h0000_0003);
  endtask
  task automatic t_async(input logic [1:0] md, input logic pe,
                         input logic od);
    logic [1:0] r;
    logic [7:0] b;
    logic e;
    logic p;
    int nb;
    int k;
    int n;
    b = 8'hb5;
    nb = md[0] ? 8 : 7;
    p = ^(md[0] ? b : {1'b0, b[6:0]}) ^ od;
    axi_wr(`SSP_ADDR_CTRL, {3'h0, od, pe, md, 1'b1}, r);
    axi_wr(`SSP_ADDR_CMD, 8'h00, r);
    axi_wr(`SSP_ADDR_DATA, b, r);
    axi_wr(`SSP_ADDR_CMD, 8'h05, r);
    chk({pin_out.sclk_oe, pin_out.ready_oe}, 2'b00);
    n = 0;
    while (pin_out.serial_out_pin !== 1'b0 && n < 100) begin
      @(posedge clk_sys);
      n++;
    end
    repeat (6) @(posedge clk_sys);
    for (k = 0; k < nb + pe + 2; k++) begin
      if (k == 0) e = 1'b0;
      else if (k <= nb) e = b[k-1];
      else if (pe && k == nb + 1) e = p;
      else e = 1'b1;
      chk(pin_out.serial_out_pin, e);
      repeat (16) @(posedge clk_sys);
    end
    wait_irq(1'b0);
    chk(tx_irq, 1'b1);
    chk(pin_out.serial_out_pin, 1'b1);
    rd_chk(`SSP_ADDR_STAT, 32'h0000_0002, 32'h0000_0002);
    axi_wr(`SSP_ADDR_STAT, 8'h02, r);
    rd_chk(`SSP_ADDR_STAT, 32'h0000_0002, 32'h0000_0000);
    chk(tx_irq, 1'b0);
  endtask
  task automatic t_mrx(input logic [1:0] src, input logic [7:0] b);
    logic [1:0] r;
    int n;
    axi_wr(`SSP_ADDR_CTRL, {1'b0, src, 4'h0, 1'b1}, r);
    axi_wr(`SSP_ADDR_CMD, 8'h00, r);
    axi_wr(`SSP_ADDR_CMD, 8'h02, r);
    start_partner(b, 1'b0);
    axi_wr(`SSP_ADDR_CMD, 8'h0a, r);
    chk({pin_out.sclk_oe, pin_out.ready_oe}, 2'b10);
    rd_chk(`SSP_ADDR_CMD, 32'h0000_0008, 32'h0000_0008);
    n = 0;
    while (pin_out.sclk !== 1'b0 && n < 100) begin
      @(posedge clk_sys);
      n++;
    end
    n = 0;
    while (pin_out.sclk === 1'b0 && n < 100) begin
      @(posedge clk_sys);
      n++;
    end
    chk(n, 8 * (src + 1));
    wait_irq(1'b1);
    chk(rx_irq, 1'b1);
    rd_chk(`SSP_ADDR_STAT, 32'h0000_0001, 32'h0000_0001);
    rd_chk(`SSP_ADDR_DATA, 32'hffff_ffff, {24'h00_0000, b});
    rd_chk(`SSP_ADDR_CMD, 32'h0000_0008, 32'h0000_0000);
    axi_wr(`SSP_ADDR_STAT, 8'h01, r);
  endtask
  // Master transmit: each bit leaves on a fall and is judged at the rise.
  task automatic t_mtx(input logic [7:0] b);
    logic [1:0] r;
    int k;
    axi_wr(`SSP_ADDR_CTRL, 8'h01, r);
    axi_wr(`SSP_ADDR_CMD, 8'h00, r);
    axi_wr(`SSP_ADDR_CMD, 8'h01, r);
    axi_wr(`SSP_ADDR_DATA, b, r);
    axi_wr(`SSP_ADDR_CMD, 8'h05, r);
    rd_chk(`SSP_ADDR_CMD, 32'h0000_0004, 32'h0000_0004);
    for (k = 0; k < 8; k++) begin
      while (pin_out.sclk !== 1'b0) @(posedge clk_sys);
      while (pin_out.sclk === 1'b0) @(posedge clk_sys);
      chk(pin_out.serial_out_pin, b[k]);
    end
    chk(tx_irq, 1'b1);
    axi_wr(`SSP_ADDR_STAT, 8'h02, r);
    chk(tx_irq, 1'b0);
    axi_wr(`SSP_ADDR_CMD, 8'h00, r);
  endtask
  task automatic t_srx(input logic [7:0] b);
    logic [1:0] r;
    int n;
    axi_wr(`SSP_ADDR_CTRL, 8'h03, r);
    axi_wr(`SSP_ADDR_CMD, 8'h00, r);
    axi_wr(`SSP_ADDR_CMD, 8'h02, r);
    chk(pin_out.ready_pin, 1'b1);
    axi_wr(`SSP_ADDR_CMD, 8'h0a, r);
    repeat (2) @(posedge clk_sys);
    chk({pin_out.sclk_oe, pin_out.ready_oe}, 2'b01);
    chk(pin_out.ready_pin, 1'b0);
    repeat (20) @(posedge clk_sys);
    chk({pin_out.ready_pin, rx_irq}, 2'b00);
    start_partner(b, 1'b1);
    n = 0;
    while (p_sclk !== 1'b0 && n < 50) begin
      @(posedge clk_sys);
      n++;
    end
    repeat (4) @(posedge clk_sys);
    chk(pin_out.ready_pin, 1'b1);
    wait_irq(1'b1);
    rd_chk(`SSP_ADDR_DATA, 32'hffff_ffff, {24'h00_0000, b});
    axi_wr(`SSP_ADDR_STAT, 8'h01, r);
    p_drv <= 1'b0;
  endtask
  task automatic test_done();
    $display("mismatches %0d comparisons %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    rst_n = 1'b0;
    req = '0;
    tick = 4'hf;
    p_go = 1'b0;
    p_drv = 1'b0;
    p_byte = 8'h00;
    n_errors = 0;
    compares = 0;
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_reset();
    for (int k = 0; k < 6; k++) t_async({1'b1, k[0]}, k[2:1] != 0, k[2]);
    t_mrx(2'b00, 8'h3c);
    t_mrx(2'b01, 8'hc5);
    t_mtx(8'h96);
    t_srx(8'ha6);
    test_done();
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    test_done();
  end
endmodule
